// ==== amsr_regs.v ====
// monitor hysteresis, gain scale, fuse check, status and event result registers
//
// The plain strobed port was decided locally.
`include "amsr_defs.vh"
`default_nettype none
module amsr_regs #(
    parameter ERR_W = 8,
    parameter CRC_CYCLES = `AMSR_CRC_CYCLES
) (
    input wire ref_clk,
    input wire rst_b,
    input wire [`AMSR_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire [ERR_W-1:0] link_err_status,
    input wire overrun_evt,
    input wire upper_evt,
    input wire lower_evt,
    input wire above_evt,
    input wire below_evt,
    input wire trigger_mode,
    input wire twos_comp_sel,
    input wire [15:0] result_raw,
    input wire gain_auto_load,
    input wire [15:0] gain_auto_value,
    input wire fuse_crc_ok,
    output wire [6:0] upper_hysteresis_value,
    output wire [6:0] lower_hysteresis_value,
    output wire [15:0] gain_scale_value,
    output wire [11:0] upper_limit,
    output wire trim_busy,
    output wire host_ready
);
    localparam integer STARTUP_CYC =
        (`AMSR_STARTUP_NS * `AMSR_CLK_MHZ + 999) / 1000;
    localparam integer SU_W = 8;
    localparam integer CRC_W = 16;

    // trim check sequencer, one-hot
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RUN = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;

    reg [6:0] upper_hyst_ff;
    reg [6:0] lower_hyst_ff;
    reg [15:0] gain_ff;
    reg [11:0] upper_limit_ff;
    reg [15:0] upper_res_ff;
    reg [15:0] lower_res_ff;
    reg trim_fail_ff;
    reg [2:0] trim_state_ff;
    reg [2:0] nxt_trim_state;
    reg [CRC_W-1:0] crc_cnt_ff;
    reg [SU_W-1:0] startup_cnt_ff;
    reg ready_ff;
    reg reset_seen_ff;
    reg overrun_ff;
    reg upper_flag_ff;
    reg lower_flag_ff;
    reg above_ff;
    reg below_ff;
    reg [7:0] nxt_rdata;
    reg [15:0] coded_result;

    wire wr_trim = reg_wr && (reg_addr == `AMSR_TRIM_CTRL);
    wire wr_status = reg_wr && (reg_addr == `AMSR_STATUS);
    wire trim_start = wr_trim && reg_wdata[`AMSR_TRIM_START_BIT];
    wire crc_last = (crc_cnt_ff == CRC_CYCLES[CRC_W-1:0] - 16'h0001);
    wire link_fault = |link_err_status;
    wire [7:0] status_word = {ready_ff, reset_seen_ff, link_fault, overrun_ff,
                              upper_flag_ff, lower_flag_ff, above_ff, below_ff};

    assign upper_hysteresis_value = upper_hyst_ff;
    assign lower_hysteresis_value = lower_hyst_ff;
    assign gain_scale_value = gain_ff;
    assign upper_limit = upper_limit_ff;
    assign trim_busy = (trim_state_ff != ST_IDLE);
    assign host_ready = ready_ff;

    // straight binary capture flips the msb so both codings share one datapath
    always @* begin
        if (twos_comp_sel) begin
            coded_result = result_raw;
        end else begin
            coded_result = {~result_raw[15], result_raw[14:0]};
        end
    end

    // configuration registers
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            upper_hyst_ff <= 7'h00;
            lower_hyst_ff <= 7'h00;
            gain_ff <= 16'h0000;
            upper_limit_ff <= 12'h000;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `AMSR_UPPER_HYST: upper_hyst_ff <= reg_wdata[6:0];
                    `AMSR_LOWER_HYST: lower_hyst_ff <= reg_wdata[6:0];
                    `AMSR_UPPER_LIMIT_LO: upper_limit_ff[7:0] <= reg_wdata;
                    `AMSR_UPPER_LIMIT_HI: upper_limit_ff[11:8] <= reg_wdata[3:0];
                    default: begin
                    end
                endcase
            end
            // host write outranks an automatic load landing in the same cycle
            if (reg_wr && reg_addr == `AMSR_GAIN_LO) begin
                gain_ff[7:0] <= reg_wdata;
            end else if (reg_wr && reg_addr == `AMSR_GAIN_HI) begin
                gain_ff[15:8] <= reg_wdata;
            end else if (gain_auto_load) begin
                gain_ff <= gain_auto_value;
            end
        end
    end

    // event captures only in trigger mode
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            upper_res_ff <= 16'h0000;
            lower_res_ff <= 16'h0000;
        end else begin
            if (trigger_mode && upper_evt) begin
                upper_res_ff <= coded_result;
            end
            if (trigger_mode && lower_evt) begin
                lower_res_ff <= coded_result;
            end
        end
    end

    // fuse map check sequencer
    always @* begin
        case (trim_state_ff)
            ST_IDLE: nxt_trim_state = trim_start ? ST_RUN : ST_IDLE;
            ST_RUN: nxt_trim_state = crc_last ? ST_DONE : ST_RUN;
            ST_DONE: nxt_trim_state = ST_IDLE;
            default: nxt_trim_state = ST_IDLE;
        endcase
    end

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            trim_state_ff <= ST_IDLE;
            crc_cnt_ff <= 16'h0000;
            trim_fail_ff <= 1'b0;
        end else begin
            trim_state_ff <= nxt_trim_state;
            if (trim_state_ff == ST_RUN) begin
                crc_cnt_ff <= crc_cnt_ff + 16'h0001;
            end else begin
                crc_cnt_ff <= 16'h0000;
            end
            if (trim_state_ff == ST_DONE && !fuse_crc_ok) begin
                trim_fail_ff <= 1'b1;
            end else if (wr_trim && reg_wdata[`AMSR_TRIM_FAIL_BIT]) begin
                trim_fail_ff <= 1'b0;
            end
        end
    end

    // startup delay before the host may talk to the device
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            startup_cnt_ff <= 8'h00;
            ready_ff <= 1'b0;
        end else if (!ready_ff) begin
            if (startup_cnt_ff == STARTUP_CYC[SU_W-1:0] - 8'h01) begin
                ready_ff <= 1'b1;
            end else begin
                startup_cnt_ff <= startup_cnt_ff + 8'h01;
            end
        end
    end

    // sticky status flags; a set in the clearing cycle wins
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reset_seen_ff <= 1'b1;
            overrun_ff <= 1'b0;
            upper_flag_ff <= 1'b0;
            lower_flag_ff <= 1'b0;
            above_ff <= 1'b0;
            below_ff <= 1'b0;
        end else begin
            if (wr_status && reg_wdata[`AMSR_ST_RESET_BIT]) begin
                reset_seen_ff <= 1'b0;
            end
            overrun_ff <= overrun_evt |
                (overrun_ff & ~(wr_status & reg_wdata[`AMSR_ST_OVERRUN_BIT]));
            upper_flag_ff <= upper_evt |
                (upper_flag_ff & ~(wr_status & reg_wdata[`AMSR_ST_UPPER_BIT]));
            lower_flag_ff <= lower_evt |
                (lower_flag_ff & ~(wr_status & reg_wdata[`AMSR_ST_LOWER_BIT]));
            above_ff <= above_evt |
                (above_ff & ~(wr_status & reg_wdata[`AMSR_ST_ABOVE_BIT]));
            below_ff <= below_evt |
                (below_ff & ~(wr_status & reg_wdata[`AMSR_ST_BELOW_BIT]));
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        case (reg_addr)
            `AMSR_UPPER_LIMIT_LO: nxt_rdata = upper_limit_ff[7:0];
            `AMSR_UPPER_LIMIT_HI: nxt_rdata = {4'h0, upper_limit_ff[11:8]};
            `AMSR_UPPER_HYST: nxt_rdata = {1'b0, upper_hyst_ff};
            `AMSR_LOWER_HYST: nxt_rdata = {1'b0, lower_hyst_ff};
            `AMSR_GAIN_LO: nxt_rdata = gain_ff[7:0];
            `AMSR_GAIN_HI: nxt_rdata = gain_ff[15:8];
            `AMSR_TRIM_CTRL: nxt_rdata = {6'h00, trim_fail_ff, trim_busy};
            `AMSR_STATUS: nxt_rdata = status_word;
            `AMSR_UPPER_RES_LO: nxt_rdata = upper_res_ff[7:0];
            `AMSR_UPPER_RES_HI: nxt_rdata = upper_res_ff[15:8];
            `AMSR_LOWER_RES_LO: nxt_rdata = lower_res_ff[7:0];
            `AMSR_LOWER_RES_HI: nxt_rdata = lower_res_ff[15:8];
            default: nxt_rdata = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= nxt_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // amsr_regs
`default_nettype wire

// ==== amsr_defs.vh ====
// constants for the converter monitor and status register bank
`ifndef AMSR_DEFS_VH
`define AMSR_DEFS_VH
`define AMSR_ADDR_W 7
`define AMSR_UPPER_LIMIT_LO 7'h28
`define AMSR_UPPER_LIMIT_HI 7'h29
`define AMSR_UPPER_HYST 7'h2C
`define AMSR_LOWER_HYST 7'h2D
`define AMSR_GAIN_LO 7'h2E
`define AMSR_GAIN_HI 7'h2F
`define AMSR_TRIM_CTRL 7'h40
`define AMSR_STATUS 7'h41
`define AMSR_UPPER_RES_LO 7'h42
`define AMSR_UPPER_RES_HI 7'h43
`define AMSR_LOWER_RES_LO 7'h44
`define AMSR_LOWER_RES_HI 7'h45
`define AMSR_TRIM_START_BIT 0
`define AMSR_TRIM_FAIL_BIT 1
`define AMSR_ST_READY_BIT 7
`define AMSR_ST_RESET_BIT 6
`define AMSR_ST_LINK_BIT 5
`define AMSR_ST_OVERRUN_BIT 4
`define AMSR_ST_UPPER_BIT 3
`define AMSR_ST_LOWER_BIT 2
`define AMSR_ST_ABOVE_BIT 1
`define AMSR_ST_BELOW_BIT 0
`define AMSR_STATUS_RST 8'h40
`define AMSR_HYST_MASK 8'h7F
`define AMSR_TRIM_MASK 8'h03
`define AMSR_LIMIT_HI_MASK 8'h0F
`define AMSR_STARTUP_NS 1000
`define AMSR_CLK_MHZ 40
`define AMSR_CRC_CYCLES 64
`endif

// ==== amsr_regs_props.sv ====
// checker for the monitor and status register bank
`default_nettype none
module amsr_regs_props #(
    parameter ERR_W = 8,
    parameter CRC_CYCLES = 4
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [ERR_W-1:0] link_err_status,
    input wire logic upper_evt,
    input wire logic gain_auto_load,
    input wire logic [6:0] upper_hysteresis_value,
    input wire logic [6:0] lower_hysteresis_value,
    input wire logic [11:0] upper_limit,
    input wire logic [15:0] gain_scale_value,
    input wire logic trim_busy,
    input wire logic host_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] up_cnt_ff;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            up_cnt_ff <= 6'h00;
        else if (up_cnt_ff != 6'h3F)
            up_cnt_ff <= up_cnt_ff + 6'h01;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence trim_go_s;
        reg_wr && reg_addr == 7'h40 && reg_wdata[0] && !trim_busy;
    endsequence
    // bench runs CRC_CYCLES of 4: busy for the run plus one done cycle
    sequence trim_run_s;
        trim_busy [*5] ##1 !trim_busy;
    endsequence
    // event, a quiet cycle with no write, then a status read
    sequence upper_then_read_s;
        upper_evt ##1 !reg_wr ##1 (reg_rd && reg_addr == 7'h41);
    endsequence
    link_or_a: assert property (
        reg_rd && reg_addr == 7'h41 |=> reg_rdata[5] == ($past(link_err_status) != 0))
        else $error("link fault bit wrong");
    sticky_set_a: assert property (
        upper_then_read_s |=> reg_rdata[3])
        else $error("upper flag not set");
    lower_hyst_a: assert property (
        reg_wr && reg_addr == 7'h2D
        |=> {1'b0, lower_hysteresis_value} == ($past(reg_wdata) & 8'h7F))
        else $error("lower hysteresis not loaded");
    limit_load_a: assert property (
        reg_wr && reg_addr == 7'h28
        |=> upper_limit[7:0] == $past(reg_wdata))
        else $error("upper limit low byte not loaded");
    hyst_load_a: assert property (
        reg_wr && reg_addr == 7'h2C
        |=> {1'b0, upper_hysteresis_value} == ($past(reg_wdata) & 8'h7F))
        else $error("upper hysteresis not loaded");
    gain_load_a: assert property (
        reg_wr && reg_addr == 7'h2E && !gain_auto_load
        |=> gain_scale_value[7:0] == $past(reg_wdata))
        else $error("gain low byte not loaded");
    trim_run_a: assert property (trim_go_s |=> trim_run_s)
        else $error("trim check length wrong");
    busy_cause_a: assert property (
        $rose(trim_busy) |-> $past(reg_wr) && $past(reg_addr) == 7'h40)
        else $error("trim check started alone");
    ready_early_a: assert property (up_cnt_ff < 6'h26 |-> !host_ready)
        else $error("ready too early");
    ready_late_a: assert property (up_cnt_ff > 6'h2A |-> host_ready)
        else $error("ready too late");
endmodule // amsr_regs_props
bind amsr_regs amsr_regs_props #(.ERR_W(ERR_W), .CRC_CYCLES(CRC_CYCLES)) u_amsr_regs_props (
    .ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .link_err_status, .upper_evt, .gain_auto_load, .upper_hysteresis_value,
    .lower_hysteresis_value, .upper_limit,
    .gain_scale_value, .trim_busy, .host_ready);
`default_nettype wire

// ==== amsr_host.sv ====
// host model driving the register port
`default_nettype none
module amsr_host (
    input wire logic ref_clk,
    output var logic [6:0] reg_addr,
    output var logic [7:0] reg_wdata,
    output var logic reg_wr,
    output var logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        // released data must not look like the last value
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule // amsr_host
`default_nettype wire

// ==== amsr_regs_test.sv ====
// self-checking bench for the monitor and status register bank
`include "amsr_defs.vh"
`default_nettype none
module amsr_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_b, trig, twos, gload, crc_ok, reg_wr, reg_rd;
    logic [7:0] lerr, rd_d, reg_wdata, reg_rdata;
    logic [6:0] reg_addr;
    logic [4:0] evt;
    logic [15:0] raw, gval;
    logic [6:0] adr[$] = {7'h2C, 7'h2D, 7'h2E, 7'h2F, 7'h28, 7'h29};
    logic [7:0] msk[$] = {8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h0F};
    int miscompares = 0, num_checks = 0, st, v, i;
    amsr_host u_amsr_host (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    amsr_regs #(.ERR_W(8), .CRC_CYCLES(4)) u_amsr_regs (
        .ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .link_err_status(lerr), .overrun_evt(evt[4]), .upper_evt(evt[3]),
        .lower_evt(evt[2]), .above_evt(evt[1]), .below_evt(evt[0]),
        .trigger_mode(trig), .twos_comp_sel(twos), .result_raw(raw),
        .gain_auto_load(gload), .gain_auto_value(gval), .fuse_crc_ok(crc_ok),
        .upper_hysteresis_value(), .lower_hysteresis_value(), .gain_scale_value(),
        .upper_limit(), .trim_busy(), .host_ready());
    task automatic chk(input logic [6:0] a, input int exp);
        u_amsr_host.rd(a, rd_d);
        num_checks++;
        if (rd_d !== exp[7:0]) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, rd_d, exp[7:0]);
        end
    endtask
    task automatic pulse(input logic [4:0] m);
        @(posedge ref_clk);
        evt <= m;
        @(posedge ref_clk);
        evt <= 5'h00;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // about 4000 cycles, more than ten times the length of the tests
    initial begin
        #100000;
        miscompares++;
        print_verdict;
    end
    initial begin
        {rst_b, lerr, evt, trig, twos, raw, gload, gval, crc_ok} = '0;
        v = $urandom(32'h2445);
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        st = 8'h40;
        chk(`AMSR_STATUS, st);
        repeat (45) @(posedge ref_clk);
        st = 8'hC0;
        chk(`AMSR_STATUS, st);
        u_amsr_host.wr(`AMSR_STATUS, 8'h40);
        st = 8'h80;
        chk(`AMSR_STATUS, st);
        foreach (adr[k]) begin
            v = $urandom;
            u_amsr_host.wr(adr[k], v[7:0]);
            chk(adr[k], v & msk[k]);
        end
        v = $urandom;
        @(posedge ref_clk);
        gval <= v[15:0];
        gload <= 1'b1;
        raw <= ~v[15:0];
        lerr <= v[7:0] | 8'h01;
        @(posedge ref_clk);
        gload <= 1'b0;
        chk(`AMSR_GAIN_LO, v & 'hFF);
        chk(`AMSR_GAIN_HI, (v >> 8) & 'hFF);
        chk(`AMSR_STATUS, st | 'h20);
        lerr <= 8'h00;
        for (i = 0; i < 5; i++) begin
            pulse(5'h01 << i);
            st = st | (1 << i);
            chk(`AMSR_STATUS, st);
            u_amsr_host.wr(`AMSR_STATUS, 8'h01 << i);
            st = st & ~(1 << i);
            chk(`AMSR_STATUS, st);
        end
        u_amsr_host.wr(7'h30, 8'hFF);
        chk(7'h30, 0);
        u_amsr_host.wr(`AMSR_UPPER_RES_LO, 8'hA5);
        chk(`AMSR_UPPER_RES_LO, 0);
        fork
            u_amsr_host.wr(`AMSR_STATUS, 8'h08);
            pulse(5'h08);
        join
        chk(`AMSR_STATUS, st | 8);
        for (i = 0; i < 2; i++) begin
            v = $urandom;
            @(posedge ref_clk);
            trig <= 1'b1;
            twos <= i[0];
            raw <= v[15:0];
            pulse(5'h0C);
            v = i ? v : v ^ 'h8000;
            chk(`AMSR_UPPER_RES_LO, v & 'hFF);
            chk(`AMSR_UPPER_RES_HI, (v >> 8) & 'hFF);
            chk(`AMSR_LOWER_RES_LO, v & 'hFF);
            chk(`AMSR_LOWER_RES_HI, (v >> 8) & 'hFF);
        end
        for (i = 1; i >= 0; i--) begin
            @(posedge ref_clk);
            crc_ok <= i[0];
            u_amsr_host.wr(`AMSR_TRIM_CTRL, 8'h01);
            chk(`AMSR_TRIM_CTRL, 1);
            repeat (8) @(posedge ref_clk);
            chk(`AMSR_TRIM_CTRL, i ? 0 : 2);
        end
        u_amsr_host.wr(`AMSR_TRIM_CTRL, 8'h02);
        chk(`AMSR_TRIM_CTRL, 0);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        chk(`AMSR_STATUS, 'h40);
        print_verdict;
    end
endmodule // amsr_regs_test
`default_nettype wire
